// File: pkg/global_clock_source_cfg.svh
// offsets, reset values and limits of the global clock source control
`ifndef GLOBAL_CLOCK_SOURCE_CFG_SVH
`define GLOBAL_CLOCK_SOURCE_CFG_SVH

`define GCS_NET_COUNT 3
`define GCS_ADDR_SOURCE_SEL 16'hdf16
`define GCS_ADDR_MODE_BASE 16'hdf18
`define GCS_ADDR_DIV_BASE 16'hdf1c
`define GCS_ADDR_UPDATE 16'hdf40
`define GCS_ADDR_REJECT 16'hdf41
`define GCS_ADDR_STEP 16'hdf8f
`define GCS_ADDR_FREQ_BASE 16'hdfc0
`define GCS_FREQ_STRIDE 4
`define GCS_STEP_KHZ 125
`define GCS_FREQ_MAX_MHZ 550
`define GCS_REF_DEFAULT_MHZ 200
`define GCS_DIV_MIN 16'h0002
`define GCS_DIV_RESET 16'h0002
`define GCS_SOURCE_SEL_RESET 3'h0

`endif

// File: pkg/global_clock_source_pkg.sv
// types shared by the global clock source control
`default_nettype none
package global_clock_source_pkg;

   // source of one primary network
   typedef enum logic [2:0] {
      SRC_SYNTH = 3'h0,
      SRC_EXT = 3'h1,
      SRC_DIV = 3'h3,
      SRC_STEP = 3'h2,
      SRC_FPGA = 3'h6
   } src_t;

   // settings applied to one primary network
   typedef struct packed {
      src_t src;
      logic [12:0] steps;
      logic [15:0] div;
   } net_cfg_t;

   // register access from the board controller
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage : global_clock_source_pkg
`default_nettype wire

// File: rtl/global_clock_source_control.sv
// source selection and control of the three primary clock nets and ref net
`timescale 1ns/1ps
`default_nettype none
`include "global_clock_source_cfg.svh"

// Overview of operation
// - frequency accepts 0.125 MHz multiples up to 550
// - step register bits 0..2 toggle nets
// - divide source outputs synth divided by factor
// - no limit on external clock frequency
// - every net can take user FPGA clock
// - reference net has no source mux
// - reference net runs 200 MHz by default
// - source select holds one bit per net
// - update bits apply pending settings per net
module global_clock_source_control
   import global_clock_source_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire reg_req_t REG_REQ,
   output var logic [7:0] REG_RDATA,
   input wire logic [2:0] SYNTH_CLK,
   input wire logic [2:0] EXT_CLK,
   input wire logic [2:0] FPGA_CLK,
   input wire logic REF_SYNTH_CLK,
   output var logic [2:0] PRIMARY_CLOCK_NET,
   output var net_cfg_t [2:0] NET_CFG,
   output var logic REFERENCE_CLOCK_NET,
   output var logic [12:0] REFERENCE_STEPS
);

   localparam int NETS = `GCS_NET_COUNT;
   // frequency code is in 0.125 MHz steps
   localparam int MAX_STEPS = `GCS_FREQ_MAX_MHZ * 1000 / `GCS_STEP_KHZ;
   localparam int STEPS_PER_MHZ = 1000 / `GCS_STEP_KHZ;
   localparam logic [12:0] REF_STEPS =
      13'(`GCS_REF_DEFAULT_MHZ * STEPS_PER_MHZ);

   // byte address of a frequency register byte
   function automatic logic [15:0] freq_addr(input int n, input int k);
      freq_addr = 16'(`GCS_ADDR_FREQ_BASE + `GCS_FREQ_STRIDE * n + k);
   endfunction : freq_addr

   // integer MHz plus eighths must land on the step grid
   function automatic logic freq_ok(input logic [15:0] mhz,
                                    input logic [15:0] frac);
      logic [19:0] total;
      total = {1'b0, mhz, 3'h0} + {4'h0, frac};
      freq_ok = (frac < 16'(STEPS_PER_MHZ)) && (total <= 20'(MAX_STEPS)) &&
                (total != 20'h0);
   endfunction : freq_ok

   // decode of a legal source mode code
   function automatic src_t mode_of(input logic [7:0] d);
      case (d[2:0])
         3'h1: mode_of = SRC_EXT;
         3'h2: mode_of = SRC_DIV;
         3'h3: mode_of = SRC_STEP;
         default: mode_of = SRC_SYNTH;
      endcase
   endfunction : mode_of

   logic wr; // write strobe from the controller
   logic [15:0] addr; // register address
   logic [7:0] wdata; // write byte
   assign wr = REG_REQ.wr;
   assign addr = REG_REQ.addr;
   assign wdata = REG_REQ.wdata;

   logic [15:0] pend_mhz [NETS]; // pending integer MHz
   logic [15:0] pend_frac [NETS]; // pending eighths of a MHz
   src_t pend_mode [NETS]; // pending non-fpga source
   logic [15:0] pend_div [NETS]; // pending divide factor
   logic [2:0] source_sel; // one bit per net, 1 = user fpga
   logic [2:0] reject; // last update carried an off-grid frequency
   logic [2:0] step_level; // stepped clock levels
   logic [2:0] s1_synth, s2_synth, s3_synth; // synth clock sync + history
   logic [2:0] s1_ext, s2_ext; // external clock sync
   logic [2:0] s1_fpga, s2_fpga; // user fpga clock sync
   logic s1_ref, s2_ref; // reference synth sync
   logic [15:0] div_count [NETS]; // synth edges within a divided period
   logic [2:0] div_level; // divided clock levels

   // pending settings written by the controller
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         for (int n = 0; n < NETS; n++) begin
            pend_mhz[n] <= 16'h0000;
            pend_frac[n] <= 16'h0000;
            pend_mode[n] <= SRC_SYNTH;
            pend_div[n] <= `GCS_DIV_RESET;
         end
         source_sel <= `GCS_SOURCE_SEL_RESET;
      end else if (wr) begin
         for (int n = 0; n < NETS; n++) begin
            // little-endian byte pairs for MHz and fraction
            if (addr == freq_addr(n, 0)) pend_mhz[n][7:0] <= wdata;
            if (addr == freq_addr(n, 1)) pend_mhz[n][15:8] <= wdata;
            if (addr == freq_addr(n, 2)) pend_frac[n][7:0] <= wdata;
            if (addr == freq_addr(n, 3)) pend_frac[n][15:8] <= wdata;
            if (addr == 16'(`GCS_ADDR_MODE_BASE + n)) begin
               pend_mode[n] <= mode_of(wdata);
            end
            if (addr == 16'(`GCS_ADDR_DIV_BASE + 2 * n)) begin
               pend_div[n][7:0] <= wdata;
            end
            if (addr == 16'(`GCS_ADDR_DIV_BASE + 2 * n + 1)) begin
               pend_div[n][15:8] <= wdata;
            end
         end
         if (addr == `GCS_ADDR_SOURCE_SEL) begin
            source_sel <= wdata[2:0];
         end
      end
   end

   // update register applies pending settings net by net
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         for (int n = 0; n < NETS; n++) begin
            NET_CFG[n].src <= SRC_SYNTH;
            NET_CFG[n].steps <= 13'h0000;
            NET_CFG[n].div <= `GCS_DIV_RESET;
         end
         reject <= 3'h0;
      end else if (wr && addr == `GCS_ADDR_UPDATE) begin
         for (int n = 0; n < NETS; n++) begin
            if (wdata[n]) begin
               // user fpga bit overrides the mode, any net may take it
               NET_CFG[n].src <= source_sel[n] ? SRC_FPGA
                                               : pend_mode[n];
               // a factor below two would stop the clock, so clamp it
               NET_CFG[n].div <= (pend_div[n] < `GCS_DIV_MIN) ?
                                 `GCS_DIV_MIN : pend_div[n];
               // off-grid rates keep the old frequency and flag it
               if (freq_ok(pend_mhz[n], pend_frac[n])) begin
                  NET_CFG[n].steps <= 13'({pend_mhz[n], 3'h0} +
                                          {3'h0, pend_frac[n]});
                  reject[n] <= 1'b0;
               end else begin
                  reject[n] <= 1'b1;
               end
            end
         end
      end
   end

   // step register: each set bit flips its stepped clock once
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         step_level <= 3'h0;
      end else if (wr && addr == `GCS_ADDR_STEP) begin
         step_level <= step_level ^ wdata[2:0];
      end
   end

   // pin clocks are foreign to REF_CLK: two flops before use
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         s1_synth <= 3'h0;
         s2_synth <= 3'h0;
         s3_synth <= 3'h0;
         s1_ext <= 3'h0;
         s2_ext <= 3'h0;
         s1_fpga <= 3'h0;
         s2_fpga <= 3'h0;
         s1_ref <= 1'b0;
         s2_ref <= 1'b0;
      end else begin
         s1_synth <= SYNTH_CLK;
         s2_synth <= s1_synth;
         s3_synth <= s2_synth; // history for edge detect
         s1_ext <= EXT_CLK;
         s2_ext <= s1_ext;
         s1_fpga <= FPGA_CLK;
         s2_fpga <= s1_fpga;
         s1_ref <= REF_SYNTH_CLK;
         s2_ref <= s1_ref;
      end
   end

   // divider counts synth rising edges, period is div edges
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         for (int n = 0; n < NETS; n++) begin
            div_count[n] <= 16'h0000;
         end
         div_level <= 3'h0;
      end else begin
         for (int n = 0; n < NETS; n++) begin
            if (NET_CFG[n].src != SRC_DIV) begin
               // idle while not selected so a new selection starts clean
               div_count[n] <= 16'h0000;
               div_level[n] <= 1'b0;
            end else if (s2_synth[n] && !s3_synth[n]) begin
               if (div_count[n] >= NET_CFG[n].div - 16'h0001) begin
                  div_count[n] <= 16'h0000;
                  div_level[n] <= 1'b1;
               end else begin
                  div_count[n] <= div_count[n] + 16'h0001;
                  if (div_count[n] + 16'h0001 ==
                      {1'b0, NET_CFG[n].div[15:1]}) begin
                     div_level[n] <= 1'b0;
                  end
               end
            end
         end
      end
   end

   // per-net source mux; switching may glitch, as on the board
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PRIMARY_CLOCK_NET <= 3'h0;
      end else begin
         for (int n = 0; n < NETS; n++) begin
            case (NET_CFG[n].src)
               SRC_SYNTH: PRIMARY_CLOCK_NET[n] <= s2_synth[n];
               SRC_EXT: PRIMARY_CLOCK_NET[n] <= s2_ext[n];
               SRC_DIV: PRIMARY_CLOCK_NET[n] <= div_level[n];
               SRC_STEP: PRIMARY_CLOCK_NET[n] <= step_level[n];
               SRC_FPGA: PRIMARY_CLOCK_NET[n] <= s2_fpga[n];
               default: PRIMARY_CLOCK_NET[n] <= s2_synth[n];
            endcase
         end
      end
   end

   // reference net: own synth only, fixed rate, nothing writable
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         REFERENCE_CLOCK_NET <= 1'b0;
         REFERENCE_STEPS <= 13'h0000;
      end else begin
         REFERENCE_CLOCK_NET <= s2_ref;
         REFERENCE_STEPS <= REF_STEPS;
      end
   end

   // readback; step register is write only and reads zero
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_REQ.rd) begin
         REG_RDATA <= 8'h00;
         for (int n = 0; n < NETS; n++) begin
            if (addr == freq_addr(n, 0)) REG_RDATA <= pend_mhz[n][7:0];
            if (addr == freq_addr(n, 1)) REG_RDATA <= pend_mhz[n][15:8];
            if (addr == freq_addr(n, 2)) REG_RDATA <= pend_frac[n][7:0];
            if (addr == freq_addr(n, 3)) REG_RDATA <= pend_frac[n][15:8];
            if (addr == 16'(`GCS_ADDR_MODE_BASE + n)) begin
               REG_RDATA <= {5'h00, pend_mode[n]};
            end
            if (addr == 16'(`GCS_ADDR_DIV_BASE + 2 * n)) begin
               REG_RDATA <= pend_div[n][7:0];
            end
            if (addr == 16'(`GCS_ADDR_DIV_BASE + 2 * n + 1)) begin
               REG_RDATA <= pend_div[n][15:8];
            end
         end
         if (addr == `GCS_ADDR_SOURCE_SEL) REG_RDATA <= {5'h00, source_sel};
         if (addr == `GCS_ADDR_REJECT) REG_RDATA <= {5'h00, reject};
      end
   end

endmodule : global_clock_source_control
`default_nettype wire

// File: sim/clock_source_model.sv
// free-running source clocks standing at the far side of the control
`timescale 1ns/1ps
`default_nettype none
module clock_source_model (
   output var logic [2:0] synth,
   output var logic [2:0] ext,
   output var logic [2:0] fpga,
   output var logic ref_synth
);
   // odd half periods keep every edge off the 100 ns sampling grid
   for (genvar i = 0; i < 3; i++) begin : g_src
      initial begin
         synth[i] = 1'b0;
         forever #(250.01 + 80.0 * i) synth[i] = ~synth[i];
      end
      // any rate is fine on the external input, no upper bound
      initial begin
         ext[i] = 1'b1;
         forever #(90.03 + 40.0 * i) ext[i] = ~ext[i];
      end
      // user device clock output pins
      initial begin
         fpga[i] = 1'b0;
         forever #(370.07 + 80.0 * i) fpga[i] = ~fpga[i];
      end
   end
   // own synthesizer of the reference net
   initial begin
      ref_synth = 1'b0;
      forever #170.09 ref_synth = ~ref_synth;
   end
endmodule : clock_source_model
`default_nettype wire

// File: sim/global_clock_source_control_assertions.sv
// port checks of the global clock source control
`timescale 1ns/1ps
`default_nettype none
`include "global_clock_source_cfg.svh"
module global_clock_source_control_assertions
   import global_clock_source_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire reg_req_t REG_REQ,
   input wire logic [2:0] SYNTH_CLK,
   input wire logic [2:0] EXT_CLK,
   input wire logic [2:0] FPGA_CLK,
   input wire logic REF_SYNTH_CLK,
   input wire logic [2:0] PRIMARY_CLOCK_NET,
   input wire net_cfg_t [2:0] NET_CFG,
   input wire logic REFERENCE_CLOCK_NET,
   input wire logic [12:0] REFERENCE_STEPS
);
   logic [2:0] up; // cycles since reset, sticks at 4
   logic upd; // update write taken this edge
   logic stp; // step write taken this edge
   assign upd = REG_REQ.wr && REG_REQ.addr == `GCS_ADDR_UPDATE;
   assign stp = REG_REQ.wr && REG_REQ.addr == `GCS_ADDR_STEP;
   // sync flops still hold reset values for a few edges
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         up <= 3'h0;
      end else if (up != 3'h4) begin
         up <= up + 3'h1;
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   chk_ref_steps: assert property (up != 3'h0 |-> REFERENCE_STEPS == 13'h640)
      else $error("reference steps off default");
   chk_steps_max: assert property (NET_CFG[2].steps <= 13'h1130)
      else $error("steps above ceiling");
   chk_cfg_hold: assert property (!$past(upd) |-> $stable(NET_CFG))
      else $error("settings moved without update");
   chk_upd_mask: assert property (upd && !REG_REQ.wdata[1] |=> $stable(NET_CFG[1]))
      else $error("unselected net updated");
   chk_step_flip: assert property (stp && REG_REQ.wdata[0] && NET_CFG[0].src == SRC_STEP
      |-> ##2 PRIMARY_CLOCK_NET[0] != $past(PRIMARY_CLOCK_NET[0]))
      else $error("step write without level change");
   chk_div_floor: assert property (NET_CFG[0].div >= 16'h0002)
      else $error("divide factor below two");
   chk_fpga_path: assert property (up == 3'h4 && $past(NET_CFG[0].src) == SRC_FPGA
      |-> PRIMARY_CLOCK_NET[0] == $past(FPGA_CLK[0], 3))
      else $error("user clock not on net");
   chk_ref_path: assert property (up == 3'h4
      |-> REFERENCE_CLOCK_NET == $past(REF_SYNTH_CLK, 3))
      else $error("reference net not from synth");
   chk_synth_path: assert property (
      up == 3'h4 && $past(NET_CFG[0].src) == SRC_SYNTH
      |-> PRIMARY_CLOCK_NET[0] == $past(SYNTH_CLK[0], 3))
      else $error("synth clock not on net");
   chk_ext_path: assert property (
      up == 3'h4 && $past(NET_CFG[0].src) == SRC_EXT
      |-> PRIMARY_CLOCK_NET[0] == $past(EXT_CLK[0], 3))
      else $error("external clock not on net");
endmodule : global_clock_source_control_assertions
bind global_clock_source_control global_clock_source_control_assertions
   chk_u (.REF_CLK(REF_CLK), .RST(RST), .REG_REQ(REG_REQ),
   .SYNTH_CLK(SYNTH_CLK), .EXT_CLK(EXT_CLK),
   .FPGA_CLK(FPGA_CLK), .REF_SYNTH_CLK(REF_SYNTH_CLK),
   .PRIMARY_CLOCK_NET(PRIMARY_CLOCK_NET), .NET_CFG(NET_CFG),
   .REFERENCE_CLOCK_NET(REFERENCE_CLOCK_NET),
   .REFERENCE_STEPS(REFERENCE_STEPS));
`default_nettype wire

// File: sim/global_clock_source_control_tb.sv
// self-checking bench of the global clock source control
`timescale 1ns/1ps
`default_nettype none
`include "global_clock_source_cfg.svh"
module global_clock_source_control_tb
   import global_clock_source_pkg::*;
;
   logic clk, rst; // bench clock and reset
   reg_req_t req; // controller access
   logic [7:0] rdata;
   logic [2:0] synth, ext, fpga, pnet, lvl; // lvl: model step levels
   logic ref_synth, rnet;
   logic [12:0] rsteps;
   net_cfg_t [2:0] cfg;
   int fail_count, compares, exp_steps[3];
   src_t exp_src[3];
   logic [15:0] exp_div[3];
   logic [31:0] seed;
   src_t code[4] = '{SRC_SYNTH, SRC_EXT, SRC_DIV, SRC_STEP};
   logic [15:0] dv[3] = '{16'h0005, 16'h0001, 16'h8000};
   global_clock_source_control dut_u (.REF_CLK(clk), .RST(rst),
      .REG_REQ(req), .REG_RDATA(rdata), .SYNTH_CLK(synth), .EXT_CLK(ext),
      .FPGA_CLK(fpga), .REF_SYNTH_CLK(ref_synth), .PRIMARY_CLOCK_NET(pnet),
      .NET_CFG(cfg), .REFERENCE_CLOCK_NET(rnet), .REFERENCE_STEPS(rsteps));
   clock_source_model src_u (.synth(synth), .ext(ext), .fpga(fpga),
      .ref_synth(ref_synth));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic print_verdict();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict
   // strobe held through the taking edge, dropped just after it
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req = {a, d, 1'b1, 1'b0};
      @(posedge clk);
      #1 req.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 req = {a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      #1 req.rd = 1'b0;
      d = rdata;
   endtask : rd
   task automatic chk_cfg();
      for (int i = 0; i < 3; i++) begin
         check(cfg[i].src, exp_src[i]);
         check(cfg[i].steps, exp_steps[i]);
         check(cfg[i].div, exp_div[i]);
      end
   endtask : chk_cfg
   task automatic upd(input int n);
      wr(`GCS_ADDR_UPDATE, 8'(1 << n));
      @(posedge clk);
      #1 chk_cfg();
   endtask : upd
   // off-grid or out-of-range settings leave the applied steps alone
   task automatic freq(input int n, input int mhz, input int f);
      int t;
      t = mhz * 8 + f;
      for (int k = 0; k < 4; k++) begin
         wr(`GCS_ADDR_FREQ_BASE + 16'(4 * n + k),
            8'(k < 2 ? mhz >> (8 * k) : f >> (8 * (k - 2))));
      end
      if (f < 8 && t > 0 && t <= 4400) exp_steps[n] = t;
      upd(n);
   endtask : freq
   initial begin
      #400000;
      fail_count++;
      print_verdict();
   end
   initial begin
      logic [7:0] d;
      int c, e; // synth rises counted, net rises seen
      logic sp, pp; // previous synth and net levels
      req = '0;
      rst = 1'b1;
      seed = 32'hd1ef;
      lvl = 3'h0;
      for (int i = 0; i < 3; i++) begin
         exp_src[i] = SRC_SYNTH;
         exp_steps[i] = 0;
         exp_div[i] = 16'h0002;
      end
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      chk_cfg();
      // reference steps load on the first edge after release
      rd(16'h1234, d);
      check(rsteps, 13'h640);
      check(d, 8'h00);
      freq(2, 550, 0);
      freq(1, 551, 0);
      rd(`GCS_ADDR_REJECT, d);
      check(d != 8'h00, 1'b1);
      // random host settings may fall off the register grid or past 550 MHz, such values are refused
      repeat (6) freq(rnd() % 3, rnd() % 552, rnd() % 9);
      for (int n = 0; n < 3; n++) begin
         wr(`GCS_ADDR_DIV_BASE + 16'(2 * n), dv[n][7:0]);
         wr(`GCS_ADDR_DIV_BASE + 16'(2 * n + 1), dv[n][15:8]);
         exp_div[n] = dv[n] < 16'h0002 ? 16'h0002 : dv[n];
         // host picks the source before using it
         for (int m = 0; m < 4; m++) begin
            wr(`GCS_ADDR_MODE_BASE + 16'(n), 8'(m));
            exp_src[n] = code[m];
            upd(n);
            rd(`GCS_ADDR_MODE_BASE + 16'(n), d);
            check(d, 8'(code[m]));
         end
         wr(`GCS_ADDR_SOURCE_SEL, 8'(1 << n));
         exp_src[n] = SRC_FPGA;
         upd(n);
         repeat (6) @(posedge clk);
         wr(`GCS_ADDR_SOURCE_SEL, 8'h00);
         exp_src[n] = SRC_STEP;
         upd(n);
      end
      // divided net 0: synth rises between two rises of the net
      wr(`GCS_ADDR_MODE_BASE, 8'h02);
      exp_src[0] = SRC_DIV;
      upd(0);
      sp = 1'b1;
      pp = 1'b1;
      repeat (2) begin
         c = 0;
         e = 0;
         while (e < 2) begin
            @(posedge clk);
            // synth read at the edge, as the first sync flop sees it
            if (synth[0] && !sp && e == 1) c++;
            sp = synth[0];
            #1 if (pnet[0] && !pp) e++;
            pp = pnet[0];
         end
         check(c, exp_div[0]);
      end
      wr(`GCS_ADDR_MODE_BASE, 8'h03);
      exp_src[0] = SRC_STEP;
      upd(0);
      repeat (10) begin
         d = 8'(rnd());
         wr(`GCS_ADDR_STEP, d);
         lvl ^= d[2:0];
         @(posedge clk);
         #1 check(pnet, lvl);
      end
      // no host write may reach the reference setting
      check(rsteps, 13'h640);
      print_verdict();
   end
endmodule : global_clock_source_control_tb
`default_nettype wire
